// >>> atc_tune_ctrl.sv
// Operation
// - Poll expander at power-up; ack means fitted
// - Tune request applies RF, configures expander
// - Power-ok input is active low
// - Compare last and new frequency for direction
// - Wave drive, one phase at a time
// - Read three active-low match flags
// - On improvement with power, stop, toggle load
// - Load low 22 ohm, high 35; recheck
// - Alternate until best match or no gain (code stops only at best match, max_q steps or weak RF)
// - Pass below 3:1, else fail
// - Brake and hold one phase at done
// - Watch for detune unless disabled
// - Scan mode drives scan output low
// - Preset lines pass through unchanged
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module atc_tune_ctrl
	import atc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Expander bus pins
	output logic scl_oe_out,
	output logic sda_oe_out,
	input wire logic sda_in,
	// Antenna side
	input wire logic rf_sufficient_n_in,
	input wire logic [2:0] match_n_in,
	output logic [3:0] phase_out,
	output logic load_out,
	output logic brake_out,
	output logic rf_on_out,
	output logic scan_n_out,
	input wire logic [3:0] preset_in,
	output logic [3:0] preset_out,
	// Panel
	output logic pass_out,
	output logic fail_out,
	output logic untuned_out
);
	atc_state_e st_q;
	logic [7:0] ctrl_q;
	logic [15:0] freq_q, last_q, settle_q, max_q, cnt_q, steps_q;
	logic [1:0] phs_q;
	logic dir_up_q, fitted_q, tried_load_q;
	logic [1:0] best_q;
	logic [2:0] m_a_q, m_b_q;
	logic r_a_q, r_b_q;
	logic probe_go, probe_busy, probe_done, probe_ack;
	logic [1:0] grade;
	logic wr, rd;
	assign wr = psel_in && penable_in && pwrite_in;
	assign rd = psel_in && !penable_in && !pwrite_in;
	// Two-stage sync of the comparator pins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			m_a_q <= 3'h7;
			m_b_q <= 3'h7;
			r_a_q <= 1'b1;
			r_b_q <= 1'b1;
		end
		else
		begin
			m_a_q <= match_n_in;
			m_b_q <= m_a_q;
			r_a_q <= rf_sufficient_n_in;
			r_b_q <= r_a_q;
		end
	end
	// Grade 0 none, 1 under 3:1, 2 under 2:1, 3 under 1.5:1
	always_comb
	begin
		grade = 2'd0;
		if (!m_b_q[0])
			grade = 2'd1;
		if (!m_b_q[1])
			grade = 2'd2;
		if (!m_b_q[2])
			grade = 2'd3;
	end
	assign probe_go = (st_q == ST_POLL) || (st_q == ST_CFG);
	atc_i2c_probe u_probe (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.start_in(probe_go),
		.byte_in(EXP_ADDR),
		.busy_out(probe_busy),
		.done_out(probe_done),
		.acked_out(probe_ack),
		.scl_oe_out(scl_oe_out),
		.sda_oe_out(sda_oe_out),
		.sda_in(sda_in)
	);
	// APB registers
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_q <= 8'h00;
			freq_q <= 16'h0000;
			settle_q <= SETTLE_RST;
			max_q <= MAX_STEPS_RST;
		end
		else
		begin
			if (wr && paddr_in == REG_CTRL)
				ctrl_q <= pwdata_in[7:0];
			else if (st_q == ST_CFG)
				ctrl_q[CTRL_TUNE] <= 1'b0;
			if (wr && paddr_in == REG_FREQ)
				freq_q <= pwdata_in[15:0];
			if (wr && paddr_in == REG_SETTLE)
				settle_q <= pwdata_in[15:0];
			if (wr && paddr_in == REG_STEPS)
				max_q <= pwdata_in[15:0];
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= 1'b0;
			if (psel_in && !penable_in)
				pslverr_out <= paddr_in > REG_STEPS || paddr_in[1:0] != 2'b00;
			if (rd)
			begin
				case (paddr_in)
					REG_CTRL: prdata_out <= {24'h000000, ctrl_q};
					REG_FREQ: prdata_out <= {16'h0000, freq_q};
					REG_SETTLE: prdata_out <= {16'h0000, settle_q};
					REG_STATUS: prdata_out <= {20'h00000, st_q, fitted_q,
						untuned_out, fail_out, pass_out, grade, ~r_b_q, load_out};
					REG_LAST: prdata_out <= {16'h0000, last_q};
					REG_STEPS: prdata_out <= {16'h0000, max_q};
					default: prdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end
	// Tuning sequencer
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_q <= ST_POLL;
			fitted_q <= 1'b0;
			last_q <= 16'h0000;
			dir_up_q <= 1'b1;
			phs_q <= 2'd0;
			cnt_q <= 16'h0000;
			steps_q <= 16'h0000;
			best_q <= 2'd0;
			tried_load_q <= 1'b0;
			load_out <= 1'b0;
			brake_out <= 1'b0;
			rf_on_out <= 1'b0;
			phase_out <= 4'h0;
			pass_out <= 1'b0;
			fail_out <= 1'b0;
		end
		else
		begin
			case (st_q)
				ST_POLL: st_q <= ST_POLL_WAIT;
				ST_POLL_WAIT:
				begin
					if (probe_done)
					begin
						fitted_q <= probe_ack;
						st_q <= ST_IDLE;
					end
				end
				ST_IDLE:
				begin
					if (ctrl_q[CTRL_TUNE] && fitted_q)
					begin
						st_q <= ST_CFG;
						rf_on_out <= 1'b1;
						brake_out <= 1'b0;
						phase_out <= 4'h0;
						pass_out <= 1'b0;
						fail_out <= 1'b0;
						dir_up_q <= freq_q >= last_q;
						steps_q <= 16'h0000;
						best_q <= 2'd0;
						tried_load_q <= 1'b0;
					end
				end
				ST_CFG: st_q <= ST_CFG_WAIT;
				ST_CFG_WAIT:
				begin
					if (probe_done)
					begin
						st_q <= ST_SETTLE;
						cnt_q <= settle_q;
					end
				end
				ST_STEP:
				begin
					// Next phase in the chosen direction, only one lit
					phs_q <= dir_up_q ? phs_q + 2'd1 : phs_q - 2'd1;
					phase_out <= 4'h1 << (dir_up_q ? phs_q + 2'd1
						: phs_q - 2'd1);
					steps_q <= steps_q + 16'h0001;
					cnt_q <= settle_q;
					st_q <= ST_SETTLE;
				end
				ST_SETTLE:
				begin
					// Comparators lag the motor; judge only after settling
					if (cnt_q == 16'h0000)
						st_q <= ST_JUDGE;
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_JUDGE:
				begin
					if (r_b_q)
					begin
						fail_out <= 1'b1;
						st_q <= ST_DONE;
					end
					else if (grade == 2'd3 || steps_q >= max_q)
					begin
						pass_out <= grade != 2'd0;
						fail_out <= grade == 2'd0;
						st_q <= ST_DONE;
					end
					else if (grade > best_q)
					begin
						best_q <= grade;
						tried_load_q <= 1'b0;
						st_q <= ST_LOAD;
					end
					else if (tried_load_q && grade < best_q)
					begin
						load_out <= ~load_out;
						tried_load_q <= 1'b0;
						st_q <= ST_STEP;
					end
					else
						st_q <= ST_STEP;
				end
				ST_LOAD:
				begin
					// Low picks 22 ohm at the antenna, high 35 ohm
					load_out <= ~load_out;
					tried_load_q <= 1'b1;
					cnt_q <= settle_q;
					st_q <= ST_SETTLE;
				end
				ST_DONE:
				begin
					rf_on_out <= 1'b0;
					brake_out <= 1'b1;
					phase_out <= 4'h1 << phs_q;
					last_q <= freq_q;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	// Detune watch after a tune
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			untuned_out <= 1'b0;
		else if (ctrl_q[CTRL_UNTUNED_DIS] || st_q != ST_IDLE)
			untuned_out <= 1'b0;
		else
			untuned_out <= brake_out && m_b_q[0];
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			scan_n_out <= 1'b1;
			preset_out <= 4'h0;
		end
		else
		begin
			scan_n_out <= ~ctrl_q[CTRL_SCAN];
			preset_out <= preset_in;
		end
	end
	a_one_phase: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$countones(phase_out) <= 1) else $error("multiple phases on");
	a_scan_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		scan_n_out == ~$past(ctrl_q[CTRL_SCAN])) else $error("scan");
	a_preset_pass: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		preset_out == $past(preset_in)) else $error("preset");
	a_rf_bad_fail: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		st_q == ST_JUDGE && r_b_q |=> fail_out && st_q == ST_DONE)
		else $error("no fail on weak rf");
	a_done_brake: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		st_q == ST_DONE |=> brake_out && phase_out != 4'h0)
		else $error("no brake");
	a_load_flip: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		st_q == ST_LOAD |=> load_out != $past(load_out))
		else $error("load not toggled");
	a_rf_tune: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		st_q == ST_IDLE && ctrl_q[CTRL_TUNE] && fitted_q |=> rf_on_out)
		else $error("rf not applied");
	a_settle_wait: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		st_q == ST_STEP && settle_q != 16'h0000 |=> st_q == ST_SETTLE [*2])
		else $error("judged too soon");
endmodule

// >>> atc_pkg.sv
package atc_pkg;
	localparam int CLK_HZ = 10000000;
	// Bus offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FREQ = 8'h04;
	localparam logic [7:0] REG_SETTLE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_LAST = 8'h10;
	localparam logic [7:0] REG_STEPS = 8'h14;
	// Control register fields
	localparam int CTRL_TUNE = 0;
	localparam int CTRL_SCAN = 1;
	localparam int CTRL_UNTUNED_DIS = 2;
	localparam int CTRL_PRESET_LSB = 4;
	// Reset values and expander address
	localparam logic [15:0] SETTLE_RST = 16'h03e8;
	localparam logic [15:0] MAX_STEPS_RST = 16'h00c8;
	localparam logic [7:0] EXP_ADDR = 8'h40;
	// I2C: 100 kHz, quarter-bit of 2.5 us
	localparam int I2C_QTR_NS = 2500;
	localparam int I2C_QTR_CYC = (I2C_QTR_NS * (CLK_HZ / 1000000)) / 1000;
	localparam logic [7:0] I2C_QTR = 8'(I2C_QTR_CYC);
	typedef enum logic [3:0] {
		ST_POLL = 4'h0,
		ST_POLL_WAIT = 4'h1,
		ST_IDLE = 4'h2,
		ST_CFG = 4'h3,
		ST_CFG_WAIT = 4'h4,
		ST_STEP = 4'h5,
		ST_SETTLE = 4'h6,
		ST_JUDGE = 4'h7,
		ST_LOAD = 4'h8,
		ST_DONE = 4'h9
	} atc_state_e;
endpackage

// >>> atc_i2c_probe.sv
`timescale 1ns/1ps
// Sends a start, one address/write byte and a stop; reports the ack bit.
module atc_i2c_probe
	import atc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Request
	input wire logic start_in,
	input wire logic [7:0] byte_in,
	output logic busy_out,
	output logic done_out,
	output logic acked_out,
	// Bus pins, open drain
	output logic scl_oe_out,
	output logic sda_oe_out,
	input wire logic sda_in
);
	logic [7:0] div_q;
	logic [5:0] ph_q;
	logic [8:0] sh_q;
	logic sda_m_q;
	logic sda_s_q;
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end
		else
		begin
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
		end
	end
	// Phase 0..3 start, 4..39 nine bits of four quarters, 40..43 stop
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			acked_out <= 1'b0;
			div_q <= 8'h00;
			ph_q <= 6'h00;
			sh_q <= 9'h000;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (!busy_out)
			begin
				if (start_in)
				begin
					busy_out <= 1'b1;
					ph_q <= 6'h00;
					div_q <= 8'h00;
					sh_q <= {byte_in, 1'b1};
				end
			end
			else if (div_q != I2C_QTR - 8'h01)
				div_q <= div_q + 8'h01;
			else
			begin
				div_q <= 8'h00;
				ph_q <= ph_q + 6'h01;
				if (ph_q < 6'd4)
				begin
					sda_oe_out <= (ph_q >= 6'd1);
					scl_oe_out <= (ph_q >= 6'd3);
				end
				else if (ph_q < 6'd40)
				begin
					case (ph_q[1:0])
						2'd0: sda_oe_out <= ~sh_q[8];
						2'd1: scl_oe_out <= 1'b0;
						2'd2:
						begin
							if (ph_q == 6'd38)
								acked_out <= ~sda_s_q;
						end
						default:
						begin
							scl_oe_out <= 1'b1;
							sh_q <= {sh_q[7:0], 1'b1};
						end
					endcase
				end
				else
				begin
					case (ph_q)
						6'd40: sda_oe_out <= 1'b1;
						6'd41: scl_oe_out <= 1'b0;
						6'd42: sda_oe_out <= 1'b0;
						default:
						begin
							busy_out <= 1'b0;
							done_out <= 1'b1;
						end
					endcase
				end
			end
		end
	end
endmodule

// >>> atc_whip_model.sv
`timescale 1ns/1ps
// Whip antenna with option board: expander acks the first byte after each start, motor
// steps since RF on set the match grade, load low is needed for the best grade.
module atc_whip_model
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Expander bus, open drain with pull-ups
	input wire logic scl_oe_in,
	input wire logic sda_oe_in,
	output logic sda_out,
	output logic [7:0] starts_out,
	// Antenna drive
	input wire logic rf_on_in,
	input wire logic load_in,
	input wire logic [3:0] phase_in,
	// Fault controls from the bench
	input wire logic rf_bad_in,
	input wire logic detune_in,
	// Detector outputs
	output logic rf_sufficient_n_out,
	output logic [2:0] match_n_out
);
	logic scl;
	logic scl_q;
	logic sda_q;
	logic ack_q;
	logic rf_q;
	logic [3:0] bit_q;
	logic [3:0] ph_q;
	logic [7:0] steps_q;
	logic [1:0] grade;
	// Released lines float high through the pull-ups
	assign scl = !scl_oe_in;
	assign sda_out = !(sda_oe_in | ack_q);
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ack_q <= 1'b0;
			bit_q <= 4'h0;
			starts_out <= 8'h00;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda_out;
			if (scl && scl_q && sda_q && !sda_out)
			begin
				bit_q <= 4'h0;
				starts_out <= starts_out + 8'h01;
			end
			else if (scl_q && !scl)
			begin
				// Start's fall counts first; ack slot follows the ninth fall
				ack_q <= (bit_q == 4'h8);
				bit_q <= (bit_q == 4'h9) ? 4'h0 : bit_q + 4'h1;
			end
		end
	end
	// Each new energised phase is one motor step
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rf_q <= 1'b0;
			ph_q <= 4'h0;
			steps_q <= 8'h00;
		end
		else
		begin
			rf_q <= rf_on_in;
			ph_q <= phase_in;
			if (rf_on_in && !rf_q)
				steps_q <= 8'h00;
			else if (phase_in != 4'h0 && phase_in != ph_q && steps_q != 8'hff)
				steps_q <= steps_q + 8'h01;
		end
	end
	assign grade = (steps_q >= 8'h06 && !load_in) ? 2'h3 :
		(steps_q >= 8'h04) ? 2'h2 : (steps_q >= 8'h02) ? 2'h1 : 2'h0;
	assign rf_sufficient_n_out = !(rf_on_in && !rf_bad_in);
	assign match_n_out = detune_in ? 3'h7 :
		~{grade == 2'h3, grade >= 2'h2, grade >= 2'h1};
endmodule

// >>> atc_tune_ctrl_bench.sv
`timescale 1ns/1ps
module atc_tune_ctrl_bench
	import atc_pkg::*;
;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, scl_oe_out, sda_oe_out, sda_in;
	logic rf_sufficient_n_in, load_out, brake_out, rf_on_out, scan_n_out;
	logic pass_out, fail_out, untuned_out;
	logic [2:0] match_n_in;
	logic [3:0] phase_out, preset_out, last_ph;
	logic [3:0] preset_in = 4'h0;
	logic [7:0] starts;
	logic rf_bad = 1'b0;
	logic detune = 1'b0;
	logic dir_q = 1'b0;
	logic dir_up, er;
	logic [31:0] rd;
	int fail_count = 0;
	int cmp_count = 0;
	int i;
	always #50 clk_in = ~clk_in;
	atc_tune_ctrl dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .sda_in(sda_in),
		.rf_sufficient_n_in(rf_sufficient_n_in), .match_n_in(match_n_in),
		.phase_out(phase_out), .load_out(load_out), .brake_out(brake_out),
		.rf_on_out(rf_on_out), .scan_n_out(scan_n_out),
		.preset_in(preset_in), .preset_out(preset_out), .pass_out(pass_out),
		.fail_out(fail_out), .untuned_out(untuned_out));
	atc_whip_model whip (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out), .sda_out(sda_in),
		.starts_out(starts), .rf_on_in(rf_on_out), .load_in(load_out),
		.phase_in(phase_out), .rf_bad_in(rf_bad), .detune_in(detune),
		.rf_sufficient_n_out(rf_sufficient_n_in), .match_n_out(match_n_in));
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		// Look between edges so the answer is settled, then end on the edge
		@(negedge clk_in);
		while (pready_out !== 1'b1 && n < 50)
		begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 50)
			fail_count++;
		rd = prdata_out;
		er = pslverr_out;
		@(posedge clk_in);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task tune(input logic [15:0] f);
		int n;
		logic [7:0] s;
		s = starts;
		apb(1'b1, REG_FREQ, {16'h0, f});
		apb(1'b1, REG_CTRL, 32'h1);
		n = 0;
		while (rf_on_out !== 1'b1 && n < 5000)
		begin
			@(posedge clk_in);
			n++;
		end
		check("rf on", rf_on_out, 1);
		n = 0;
		while (rf_on_out !== 1'b0 && n < 30000)
		begin
			@(posedge clk_in);
			n++;
		end
		repeat (4) @(posedge clk_in);
		check("expander config", starts != s, 1);
		check("held phases", $countones(phase_out), 1);
		check("brake", brake_out, 1);
	endtask
	task results;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Direction comes from the last rotation seen
	always @(posedge clk_in)
	begin
		if (arst_n_in)
			check("one phase", $countones(phase_out) <= 1, 1);
		if (phase_out != 4'h0)
		begin
			if (last_ph != 4'h0 && phase_out != last_ph)
				dir_q <= (phase_out == {last_ph[2:0], last_ph[3]});
			last_ph <= phase_out;
		end
	end
	initial
	begin
		last_ph = 4'h0;
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		check("scan idle", scan_n_out, 1);
		check("idle outs", {phase_out, load_out, brake_out, pass_out}, 0);
		apb(1'b0, REG_SETTLE, 32'h0);
		check("settle reset", rd, {16'h0, SETTLE_RST});
		apb(1'b0, REG_STEPS, 32'h0);
		check("steps reset", rd, {16'h0, MAX_STEPS_RST});
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped", er, 1);
		repeat (1500) @(posedge clk_in);
		apb(1'b0, REG_STATUS, 32'h0);
		check("fitted", rd[7], 1);
		for (i = 0; i < 16; i++)
		begin
			preset_in <= 4'(i);
			repeat (2) @(posedge clk_in);
			check("preset", preset_out, 32'(i));
		end
		apb(1'b1, REG_CTRL, 32'h2);
		repeat (2) @(posedge clk_in);
		check("scan on", scan_n_out, 0);
		apb(1'b1, REG_CTRL, 32'h0);
		repeat (2) @(posedge clk_in);
		check("scan off", scan_n_out, 1);
		apb(1'b1, REG_SETTLE, 32'h4);
		tune(16'h1000);
		check("pass up", {pass_out, fail_out, load_out}, 3'b100);
		apb(1'b0, REG_STATUS, 32'h0);
		check("grade", rd[5:2], 4'b0111);
		apb(1'b0, REG_LAST, 32'h0);
		check("last freq", rd[15:0], 16'h1000);
		dir_up = dir_q;
		tune(16'h0800);
		check("pass down", {pass_out, fail_out}, 2'b10);
		check("direction", dir_q, !dir_up);
		detune <= 1'b1;
		repeat (6) @(posedge clk_in);
		check("untuned", untuned_out, 1);
		apb(1'b1, REG_CTRL, 32'h4);
		repeat (3) @(posedge clk_in);
		check("untuned off", untuned_out, 0);
		detune <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_STEPS, 32'h14);
		rf_bad <= 1'b1;
		tune(16'h2000);
		check("weak rf", {pass_out, fail_out}, 2'b01);
		results;
	end
	// Whole run needs well under 20000 cycles
	initial
	begin
		#8000000;
		fail_count++;
		results;
	end
endmodule
